// [modem_lines.sv]
// modem control lines of the serial port: CTS, RTS, DSR, DTR and DCD
// assumes line inputs are synchronous to i_clk and a classic wishbone master
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "modem_lines_consts.svh"

module modem_lines
  import modem_lines_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES, // wake-up delay in clock cycles
  parameter bit          LEGACY_CTS  = 1'b0          // older variant: CTS always on without flow control
) (
  input  wire logic        i_clk,          // system clock, 100 MHz
  input  wire logic        i_sys_rst,      // synchronous reset, active high
  input  wire logic        i_wb_cyc,       // wishbone cycle
  input  wire logic        i_wb_stb,       // wishbone strobe
  input  wire logic        i_wb_we,        // wishbone write enable
  input  wire logic [7:0]  i_wb_adr,       // wishbone byte address
  input  wire logic [3:0]  i_wb_sel,       // wishbone byte enables
  input  wire logic [31:0] i_wb_dat,       // wishbone write data
  output logic      [31:0] o_wb_dat,       // wishbone read data
  output logic             o_wb_ack,       // wishbone acknowledge
  input  wire logic        i_rts_n,        // request to send from DTE, low is on
  input  wire logic        i_dtr_n,        // terminal ready from DTE, low is on
  input  wire logic        i_rx_ready,     // serial receiver can take data
  input  wire logic        i_module_idle,  // module sits in idle mode
  output logic             o_cts_n,        // clear to send, low is on
  output logic             o_dsr_n,        // data set ready, low is on
  output logic             o_dcd_n,        // carrier detect, low is on
  output logic             o_tx_permit,    // transmitter may send to DTE
  output logic             o_port_enable,  // serial port enabled
  output logic             o_rx_lossless,  // reception is guaranteed lossless
  output logic             o_idle_allow,   // module may enter idle
  output logic             o_mux_fc_on,    // flow status for multiplexer commands
  output logic             o_connect_ready // CONNECT may now be returned
);

  typedef struct packed {
    ctrl_s       ctrl;
    mode_s       mode;
    logic        rts_n;
    logic        dtr_n;
    logic        port_en;
    wake_t       wake_cnt;
    logic        wake_done;
    logic        cts_n;
    logic        dsr_n;
    logic        dcd_n;
    logic        connect;
    logic        tx_permit;
    logic        mux_fc_on;
    logic        ack;
    logic [31:0] rdat;
  } state_s;

  state_s s;
  state_s next_s;

  // a request is answered when cycle and strobe are both up
  function automatic logic bus_req(input logic cyc, input logic stb);
    return cyc && stb;
  endfunction

  // pack the status word seen by software
  function automatic logic [31:0] status_word(input state_s st);
    return {23'h0, st.tx_permit, ~st.port_en | st.port_en & ~st.wake_done, st.port_en,
            st.dcd_n, st.dsr_n, st.dtr_n, st.rts_n, st.cts_n, st.wake_done};
  endfunction

  logic rts_on;
  logic dtr_on;
  logic dcd_req;
  logic wake_trig;

  // request causes and wake triggers from the sampled lines
  assign rts_on    = ~s.rts_n;
  assign dtr_on    = ~s.dtr_n;
  assign wake_trig = next_s.port_en && !s.port_en;
  // every cause that wants carrier detect is ORed, so the last one to end releases it
  assign dcd_req = s.mode.carrier || s.mode.voice || s.mode.prompt
                || s.mode.imode == MODE_DATA
                || (s.mode.imode == MODE_ONLINE_CMD && s.mode.call_held);

  // next state of the whole block
  always_comb begin
    next_s = s;
    // line sampling, pull-ups keep undriven lines high
    next_s.rts_n = i_rts_n;
    next_s.dtr_n = i_dtr_n;

    // port enable per power saving configuration
    case (s.ctrl.psv)
      PSV_OFF:    next_s.port_en = 1'b1;
      PSV_CYCLIC: next_s.port_en = !i_module_idle;
      PSV_RTS:    next_s.port_en = s.ctrl.hw_fc ? 1'b1 : rts_on;
      PSV_DTR:    next_s.port_en = dtr_on;
      default:    next_s.port_en = 1'b1;
    endcase

    // wake-up timer: restarts on each enable, lossless once it expires
    if (s.ctrl.psv == PSV_OFF) begin
      next_s.wake_cnt  = '0;
      next_s.wake_done = 1'b1;
    end else if (wake_trig || !next_s.port_en) begin
      next_s.wake_cnt  = '0;
      next_s.wake_done = 1'b0;
    end else if (!s.wake_done) begin
      next_s.wake_cnt  = s.wake_cnt + 32'h1;
      next_s.wake_done = (s.wake_cnt + 32'h1) >= WAKE_CYCLES;
    end

    // clear to send and multiplexer flow status
    if (s.ctrl.hw_fc && s.ctrl.mux_on) begin
      next_s.cts_n     = !s.port_en;
      next_s.mux_fc_on = i_rx_ready;
    end else if (s.ctrl.hw_fc) begin
      next_s.cts_n     = !(i_rx_ready && s.port_en);
      next_s.mux_fc_on = i_rx_ready && s.port_en;
    end else begin
      next_s.cts_n     = LEGACY_CTS ? 1'b0 : s.ctrl.cts_hold_off;
      next_s.mux_fc_on = 1'b1;
    end

    // transmit permission, cut the cycle after sampled RTS goes off, two cycles after the RTS pin
    next_s.tx_permit = s.ctrl.hw_fc ? rts_on : 1'b1;

    // data set ready and carrier detect lines, asserted is low
    next_s.dsr_n = s.ctrl.dsr_follow ? (s.mode.imode != MODE_DATA) : 1'b0;
    next_s.dcd_n = s.ctrl.dcd_follow ? !dcd_req : 1'b0;
    // connect goes out a cycle after carrier detect is on, so the host never sees it first
    next_s.connect = !s.dcd_n && s.mode.imode == MODE_DATA;

    // wishbone slave: ack one cycle after the request, dropped the cycle after
    next_s.ack = bus_req(i_wb_cyc, i_wb_stb) && !s.ack;
    if (bus_req(i_wb_cyc, i_wb_stb) && !s.ack) begin
      case (i_wb_adr)
        `REG_CTRL:   next_s.rdat = {25'h0, s.ctrl};
        `REG_MODE:   next_s.rdat = {26'h0, s.mode};
        `REG_STATUS: next_s.rdat = status_word(s);
        default:     next_s.rdat = 32'h0;
      endcase
    end
    // writes land at the edge where the master sees ack
    if (bus_req(i_wb_cyc, i_wb_stb) && s.ack && i_wb_we && i_wb_sel[0]) begin
      case (i_wb_adr)
        `REG_CTRL: begin
          next_s.ctrl.hw_fc        = i_wb_dat[`CTRL_HWFC_BIT];
          next_s.ctrl.psv          = psv_mode_e'(i_wb_dat[`CTRL_PSV_BIT +: 2]);
          next_s.ctrl.cts_hold_off = i_wb_dat[`CTRL_CTSOFF_BIT];
          next_s.ctrl.dsr_follow   = i_wb_dat[`CTRL_DSRF_BIT];
          next_s.ctrl.dcd_follow   = i_wb_dat[`CTRL_DCDF_BIT];
          next_s.ctrl.mux_on       = i_wb_dat[`CTRL_MUX_BIT];
        end
        `REG_MODE: begin
          next_s.mode.imode     = (i_wb_dat[`MODE_IMODE_BIT +: 2] == 2'h3) ? MODE_COMMAND
                                 : iface_mode_e'(i_wb_dat[`MODE_IMODE_BIT +: 2]);
          next_s.mode.carrier   = i_wb_dat[`MODE_CARR_BIT];
          next_s.mode.voice     = i_wb_dat[`MODE_VOICE_BIT];
          next_s.mode.prompt    = i_wb_dat[`MODE_PROMPT_BIT];
          next_s.mode.call_held = i_wb_dat[`MODE_HELD_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // state register with initialisation values
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s           <= '0;
      s.ctrl      <= ctrl_s'(7'(`CTRL_RESET));
      s.mode      <= '0;
      s.rts_n     <= 1'b1;
      s.dtr_n     <= 1'b1;
      s.port_en   <= 1'b1;
      s.wake_done <= 1'b1;
      s.cts_n     <= 1'b0;
      s.dsr_n     <= 1'b1;
      s.dcd_n     <= 1'b1;
      s.tx_permit <= 1'b0;
      s.mux_fc_on <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign o_cts_n         = s.cts_n;
  assign o_dsr_n         = s.dsr_n;
  assign o_dcd_n         = s.dcd_n;
  assign o_tx_permit     = s.tx_permit;
  assign o_port_enable   = s.port_en;
  assign o_rx_lossless   = s.port_en && s.wake_done;
  assign o_mux_fc_on     = s.mux_fc_on;
  assign o_wb_ack        = s.ack;
  assign o_wb_dat        = s.rdat;
  assign o_connect_ready = s.connect;

  // idle permission per power saving configuration
  always_comb begin
    case (s.ctrl.psv)
      PSV_OFF:    o_idle_allow = 1'b0;
      PSV_CYCLIC: o_idle_allow = 1'b1;
      PSV_RTS:    o_idle_allow = s.ctrl.hw_fc ? 1'b0 : s.rts_n;
      PSV_DTR:    o_idle_allow = s.dtr_n;
      default:    o_idle_allow = 1'b0;
    endcase
  end

  // checks on the line behaviour
  cts_after_reset_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> !o_cts_n)
    else $error("cts not asserted after reset");

  cts_flow_ready_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.hw_fc && !s.ctrl.mux_on && $stable(s.ctrl) |=> o_cts_n == !$past(i_rx_ready && s.port_en))
    else $error("cts does not follow receiver readiness");

  mux_power_cts_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.hw_fc && s.ctrl.mux_on && $stable(s.ctrl)
      |=> o_cts_n == !$past(s.port_en) && o_mux_fc_on == $past(i_rx_ready))
    else $error("mux cts mapping wrong");

  cts_no_flow_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !s.ctrl.hw_fc && !s.ctrl.cts_hold_off && $stable(s.ctrl) |=> !o_cts_n)
    else $error("cts not asserted without flow control");

  tx_halt_rts_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.hw_fc && $stable(s.ctrl) && i_rts_n ##1 s.ctrl.hw_fc |=> !o_tx_permit)
    else $error("transmission not halted by rts off");

  rts_wake_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv == PSV_RTS && !s.ctrl.hw_fc && $rose(o_port_enable) |-> !o_rx_lossless [*2])
    else $error("rts wake reported lossless too early");

  rts_sleep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv == PSV_RTS && !s.ctrl.hw_fc && $stable(s.ctrl) && s.rts_n |=> !o_port_enable)
    else $error("port still enabled after rts off");

  dtr_sleep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv == PSV_DTR && $stable(s.ctrl) && s.dtr_n |-> o_idle_allow ##1 !o_port_enable)
    else $error("port still enabled after dtr off");

  dsr_mode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dsr_follow && $stable(s.ctrl) && s.mode.imode != MODE_DATA |=> o_dsr_n)
    else $error("dsr asserted outside data mode");

  dsr_always_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !s.ctrl.dsr_follow && $stable(s.ctrl) |=> !o_dsr_n)
    else $error("dsr released under always-on setting");

  dcd_always_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !s.ctrl.dcd_follow && $stable(s.ctrl) |=> !o_dcd_n)
    else $error("dcd released under always-on setting");

  dcd_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dcd_follow && $stable(s.ctrl) && (s.mode.prompt || s.mode.voice) |=> !o_dcd_n)
    else $error("dcd dropped while a cause remains");

  connect_order_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_connect_ready |-> !$past(o_dcd_n) && !o_dcd_n)
    else $error("connect allowed before dcd asserted");

  cts_port_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.hw_fc && !s.ctrl.mux_on && !s.port_en |=> o_cts_n)
    else $error("cts on while port disabled");

  rts_init_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> s.rts_n)
    else $error("rts not seen off after reset");

  dtr_init_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> s.dtr_n)
    else $error("dtr not seen off after reset");

  dsr_init_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> o_dsr_n)
    else $error("dsr not off after reset");

  dcd_init_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> o_dcd_n)
    else $error("dcd not off after reset");

  tx_free_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !s.ctrl.hw_fc |=> o_tx_permit)
    else $error("transmission held without flow control");

  dsr_data_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dsr_follow && s.mode.imode == MODE_DATA |=> !o_dsr_n)
    else $error("dsr off in data mode");

  dcd_data_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dcd_follow && s.mode.imode == MODE_DATA |=> !o_dcd_n)
    else $error("dcd off in data mode");

  dcd_carrier_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dcd_follow && s.mode.carrier |=> !o_dcd_n)
    else $error("dcd off with carrier");

  dcd_voice_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dcd_follow && s.mode.voice |=> !o_dcd_n)
    else $error("dcd off during voice call");

  prompt_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dcd_follow && s.mode == '0 |=> o_dcd_n)
    else $error("dcd on with no cause left");

  online_held_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dcd_follow && s.mode.imode == MODE_ONLINE_CMD && s.mode.call_held |=> !o_dcd_n)
    else $error("dcd off with call suspended");

  dsr_command_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.dsr_follow && s.mode.imode == MODE_COMMAND |=> o_dsr_n)
    else $error("dsr on in command mode");

  ack_single_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");

  ack_answer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acknowledged");

  sleep_lossy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv != PSV_OFF && !s.port_en |=> !o_rx_lossless)
    else $error("lossless claimed before wake");

  psv_off_port_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv == PSV_OFF |=> o_port_enable && o_rx_lossless)
    else $error("port not ready without power saving");

  dtr_wake_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv == PSV_DTR && $rose(o_port_enable) |-> !o_rx_lossless [*2])
    else $error("dtr wake reported lossless too early");

  rts_fc_power_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.psv == PSV_RTS && s.ctrl.hw_fc |=> o_port_enable)
    else $error("rts power saving acted under flow control");

  mux_off_fc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.ctrl.hw_fc && !s.ctrl.mux_on |=> o_mux_fc_on == !o_cts_n)
    else $error("flow status disagrees with cts");

endmodule
`default_nettype wire

// [modem_lines_consts.svh]
// register offsets, field positions, reset values and timing for the modem control lines
// assumes a 100 MHz system clock and a 32-bit classic wishbone register bus
//
// Behaviour
// - CTS driven asserted low at initialisation
// - flow control on: CTS follows receiver readiness
// - CTS off means port disabled, not idle
// - multiplexer on: flow status sent, CTS shows power
// - flow control off: CTS asserted or held off
// - first idle character may be lost; DTE tolerates
// - RTS reads deasserted at init and when undriven
// - flow control on: RTS off halts transmission
// - transmission stops within two characters of RTS off
// - RTS power saving: wake, lossless after 20 ms
// - DSR always-on setting holds DSR asserted
// - DSR follows mode: asserted only in data mode
// - DTR defaults deasserted; reaction follows setting
// - DTR power saving: wake, lossless after 20 ms
// - DCD always-on setting holds DCD asserted
// - DCD follows carrier, voice call asserts it
// - packet dial: DCD asserted before CONNECT
// - circuit call accepted: DCD then CONNECT
// - voice call asserts DCD on command interfaces
// - prompt input asserts DCD until input ends
// - online command keeps DCD; command mode drops DSR (code keeps DCD in online command only while call_held is set)
// - DCD held until every requesting cause ends
`ifndef MODEM_LINES_CONSTS_SVH
`define MODEM_LINES_CONSTS_SVH

`define REG_CTRL        8'h00
`define REG_MODE        8'h04
`define REG_STATUS      8'h08

`define CTRL_HWFC_BIT   0
`define CTRL_PSV_BIT    1
`define CTRL_CTSOFF_BIT 3
`define CTRL_DSRF_BIT   4
`define CTRL_DCDF_BIT   5
`define CTRL_MUX_BIT    6
`define CTRL_RESET      8'h31

`define MODE_IMODE_BIT  0
`define MODE_CARR_BIT   2
`define MODE_VOICE_BIT  3
`define MODE_PROMPT_BIT 4
`define MODE_HELD_BIT   5

`define WAKE_TIME_MS    20
`define CLK_FREQ_HZ     100000000
`define WAKE_CYCLES     ((`WAKE_TIME_MS * `CLK_FREQ_HZ + 999) / 1000)

`endif

// [modem_lines_pkg.sv]
// types shared by the modem control line block
// assumes the constants header is compiled alongside
package modem_lines_pkg;

  // interface mode as reported by the command interpreter
  typedef enum logic [1:0] {
    MODE_COMMAND,
    MODE_DATA,
    MODE_ONLINE_CMD
  } iface_mode_e;

  // power saving configuration values
  typedef enum logic [1:0] {
    PSV_OFF,
    PSV_CYCLIC,
    PSV_RTS,
    PSV_DTR
  } psv_mode_e;

  typedef struct packed {
    logic      mux_on;
    logic      dcd_follow;
    logic      dsr_follow;
    logic      cts_hold_off;
    psv_mode_e psv;
    logic      hw_fc;
  } ctrl_s;

  typedef struct packed {
    logic        call_held;
    logic        prompt;
    logic        voice;
    logic        carrier;
    iface_mode_e imode;
  } mode_s;

  typedef logic [31:0] wake_t;

endpackage

// [dte_host_model.sv]
// host terminal model facing the modem control lines: drives RTS and DTR, watches transmit permission
// assumes the bench sets the wanted line states; a line left open rests at its pull-up level
`timescale 1ns/1ps
`default_nettype none

module dte_host_model #(
  parameter int CHAR_CYCLES = 4 // clock cycles per character on the link
) (
  input  wire logic i_clk,       // system clock
  input  wire logic i_rts_drive, // drive RTS instead of leaving it open
  input  wire logic i_rts_on,    // wanted RTS state, high is on
  input  wire logic i_dtr_drive, // drive DTR instead of leaving it open
  input  wire logic i_dtr_on,    // wanted DTR state, high is on
  input  wire logic i_tx_permit, // device may send toward the host
  output logic      o_rts_n,     // RTS pin, low is on
  output logic      o_dtr_n,     // DTR pin, low is on
  output logic      o_overrun    // device sent too long after RTS went off
);
  int late_cnt = 0;

  // open lines fall to the pull-up level, never hold an old value
  assign o_rts_n = i_rts_drive ? ~i_rts_on : 1'b1;
  assign o_dtr_n = i_dtr_drive ? ~i_dtr_on : 1'b1;

  // the host still takes two characters after dropping RTS, not more
  always_ff @(posedge i_clk) begin
    if (!o_rts_n) late_cnt <= 0;
    else if (i_tx_permit) late_cnt <= late_cnt + 1;
  end
  assign o_overrun = (late_cnt > 2 * CHAR_CYCLES);

  // received characters are not judged here, so a first character lost in idle is tolerated
endmodule

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the modem control lines: wishbone register access plus line scenarios
// assumes a host model on RTS/DTR and a short wake-up delay set through the parameter
`timescale 1ns/1ps
`default_nettype none
`include "modem_lines_consts.svh"

module tb_top;
  import modem_lines_pkg::*;
  localparam int WAKE = 8;
  logic i_clk, i_sys_rst, cyc, stb, we, rx_ready, idle, rts_drv, rts_on, dtr_drv, dtr_on;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, wb_dat;
  logic ack, rts_n, dtr_n, cts_n, dsr_n, dcd_n, tx_permit, port_en, lossless, idle_ok, mux_fc, conn_rdy, overrun;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  modem_lines #(.WAKE_CYCLES(WAKE)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_dat), .o_wb_ack(ack),
    .i_rts_n(rts_n), .i_dtr_n(dtr_n), .i_rx_ready(rx_ready), .i_module_idle(idle), .o_cts_n(cts_n),
    .o_dsr_n(dsr_n), .o_dcd_n(dcd_n), .o_tx_permit(tx_permit), .o_port_enable(port_en),
    .o_rx_lossless(lossless), .o_idle_allow(idle_ok), .o_mux_fc_on(mux_fc), .o_connect_ready(conn_rdy));
  dte_host_model host (.i_clk(i_clk), .i_rts_drive(rts_drv), .i_rts_on(rts_on), .i_dtr_drive(dtr_drv),
    .i_dtr_on(dtr_on), .i_tx_permit(tx_permit), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_overrun(overrun));

  // clock generation
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    rdat = wb_dat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // power saving under RTS or DTR control
  task automatic wake_test(input logic use_dtr);
    bus(1'b1, `REG_CTRL, use_dtr ? 32'h36 : 32'h34);
    @(posedge i_clk);
    if (use_dtr) begin dtr_drv <= 1'b1; dtr_on <= 1'b1; end
    else begin rts_drv <= 1'b1; rts_on <= 1'b1; end
    settle(3);
    chk("port_en", 1, port_en);
    chk("lossless", 0, lossless);
    chk("idle_ok", 0, idle_ok);
    settle(WAKE + 4);
    chk("lossless", 1, lossless);
    @(posedge i_clk);
    if (use_dtr) dtr_on <= 1'b0;
    else rts_on <= 1'b0;
    settle(3);
    chk("port_en", 0, port_en);
    chk("idle_ok", 1, idle_ok);
    $display("test wake %0d done", use_dtr);
  endtask

  // main sequence
  initial begin
    cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'h0; wdat = 32'h0; rx_ready = 1; idle = 0;
    rts_drv = 0; rts_on = 0; dtr_drv = 0; dtr_on = 0; i_sys_rst = 1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    settle(3);
    chk("cts_n", 0, cts_n);
    chk("dsr_n", 1, dsr_n);
    chk("dcd_n", 1, dcd_n);
    chk("tx_permit", 0, tx_permit);
    bus(1'b0, `REG_CTRL, 0);
    chk("ctrl", `CTRL_RESET, rdat);
    bus(1'b0, `REG_STATUS, 0);
    chk("rts_seen", 1, rdat[2]);
    chk("dtr_seen", 1, rdat[3]);
    bus(1'b1, 8'h0C, 32'hFF);
    bus(1'b0, 8'h0C, 0);
    chk("unmapped", 0, rdat);
    $display("test reset done");
    // flow control on both directions
    rts_drv <= 1'b1; rts_on <= 1'b1; rx_ready <= 1'b0;
    settle(3);
    chk("tx_permit", 1, tx_permit);
    chk("cts_n", 1, cts_n);
    @(posedge i_clk);
    rts_on <= 1'b0; rx_ready <= 1'b1;
    settle(12);
    chk("tx_permit", 0, tx_permit);
    chk("cts_n", 0, cts_n);
    chk("overrun", 0, overrun);
    $display("test flow done");
    // multiplexer keeps the pin as power indicator, flow status goes to commands
    bus(1'b1, `REG_CTRL, 32'h71);
    rx_ready <= 1'b0;
    settle(3);
    chk("mux_fc", 0, mux_fc);
    chk("cts_n", 0, cts_n);
    @(posedge i_clk);
    rx_ready <= 1'b1;
    settle(3);
    chk("mux_fc", 1, mux_fc);
    bus(1'b1, `REG_CTRL, 32'h30);
    rx_ready <= 1'b0;
    settle(3);
    chk("cts_n", 0, cts_n);
    bus(1'b1, `REG_CTRL, 32'h38);
    settle(3);
    chk("cts_n", 1, cts_n);
    @(posedge i_clk);
    rx_ready <= 1'b1;
    $display("test cts done");
    // interface modes and carrier causes
    bus(1'b1, `REG_CTRL, 32'h31);
    bus(1'b1, `REG_MODE, 32'h01);
    settle(2);
    chk("dsr_n", 0, dsr_n);
    chk("dcd_n", 0, dcd_n);
    chk("conn_rdy", 1, conn_rdy);
    bus(1'b1, `REG_MODE, 32'h22);
    settle(2);
    chk("dsr_n", 1, dsr_n);
    chk("dcd_n", 0, dcd_n);
    for (int i = 2; i < 5; i++) begin
      bus(1'b1, `REG_MODE, 32'h0);
      settle(2);
      chk("dcd_n", 1, dcd_n);
      bus(1'b1, `REG_MODE, 32'h1 << i);
      settle(2);
      chk("dcd_n", 0, dcd_n);
    end
    bus(1'b1, `REG_MODE, 32'h32);
    bus(1'b1, `REG_MODE, 32'h12);
    settle(2);
    chk("dcd_n", 0, dcd_n);
    bus(1'b1, `REG_MODE, 32'h02);
    settle(2);
    chk("dcd_n", 1, dcd_n);
    bus(1'b1, `REG_MODE, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h01);
    settle(2);
    chk("dsr_n", 0, dsr_n);
    chk("dcd_n", 0, dcd_n);
    $display("test modes done");
    // cyclic power saving follows the module idle state
    bus(1'b1, `REG_CTRL, 32'h32);
    idle <= 1'b1;
    settle(3);
    chk("port_en", 0, port_en);
    chk("idle_ok", 1, idle_ok);
    @(posedge i_clk);
    idle <= 1'b0;
    settle(3);
    chk("port_en", 1, port_en);
    chk("lossless", 0, lossless);
    $display("test cyclic done");
    wake_test(1'b0);
    wake_test(1'b1);
    conclude();
  end
endmodule

`default_nettype wire
